// ==== src/clu_defines.vh ====
// constants for the cell path link to utopia level 2 bridge
// assumes inclusion by bare name from each design file
`ifndef CLU_DEFINES_VH
`define CLU_DEFINES_VH
`define CLU_CELL_MIN       6'h34
`define CLU_CELL_MAX       6'h38
`define CLU_CELL_PAYLOAD   6'h35
`define CLU_TAG_MAX        3'h4
`define CLU_PHY_MAX        5'h1E
`define CLU_PHY_NULL       5'h1F
`define CLU_FIFO_WIDTH     9
`define CLU_FIFO_DEPTH     8
`define CLU_FIFO_AW        3
`define CLU_RSP_DEPTH      64
`define CLU_RSP_AW         6
`define CLU_PROG_MARK      8'hFF
`define CLU_LINK_DIV       3'h3
`define CLU_LINK_DIV_W     3
`endif

// ==== src/clu_fifo.v ====
// small synchronous fifo with valid/ready on both sides
// assumes one clock, an enable freezing all state, async high reset
`timescale 1ns/100ps
`include "clu_defines.vh"
module clu_fifo #(
  parameter WIDTH = `CLU_FIFO_WIDTH,
  parameter DEPTH = `CLU_FIFO_DEPTH,
  parameter AW    = `CLU_FIFO_AW
) (
  input  wire             clk_sys,
  input  wire             sys_rst,
  input  wire             clk_en,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  reg             head_valid;
  wire            empty = (wr_ptr == rd_ptr);
  wire            full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                          (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire            pop   = !empty && (!head_valid || out_ready);
  assign in_ready  = !full;
  assign out_valid = head_valid;
  always @(posedge clk_sys) begin
    if (clk_en && in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr     <= {(AW+1){1'b0}};
      rd_ptr     <= {(AW+1){1'b0}};
      head_valid <= 1'b0;
      out_data   <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      if (in_valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        out_data   <= mem[rd_ptr[AW-1:0]];
        rd_ptr     <= rd_ptr + 1'b1;
        head_valid <= 1'b1;
      end else if (out_ready) begin
        head_valid <= 1'b0;
      end
    end
  end
endmodule

// ==== src/clu_ram.v ====
// simple dual port memory, separate write and read addresses, with registered read data
// assumes one clock and an enable that freezes all state
`timescale 1ns/100ps
`include "clu_defines.vh"
module clu_ram #(
  parameter WIDTH = 8,
  parameter DEPTH = `CLU_RSP_DEPTH,
  parameter AW    = `CLU_RSP_AW
) (
  input  wire             clk_sys,
  input  wire             clk_en,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  always @(posedge clk_sys) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// ==== src/clu_bridge.v ====
// cell path link to utopia level 2 bridge, device side
// assumes clk_sys 50 MHz; link and utopia pins asynchronous, synchronised
// Functional notes
// - incoming link data 4 or 8 bits
// - outgoing link data 4 or 8 bits
// - utopia receive data 8 bits, or 16 bits xored into one byte in cfg_utopia_wide mode
// - utopia transmit data 8 bits, upper byte zero in either cfg_utopia_wide mode
// - multi-phy master serving up to 31 phys
// - whole cell per grant, cell handshake
// - drive five-bit rx address and enable
// - cell length 52 through 56 bytes
// - link logic runs up to 50 MHz
// - receive direction prepends up to four tags
// - transmit direction strips up to four tags
// - tag settings independent per direction
// - programming cells go to interpreter
// - round-robin among phys and response generator
// - programming cells kept from phys, responses returned
// - management port utility or parallel style
// - settings loaded from serial config memory
// - frame marker with first outgoing transfer
`timescale 1ns/100ps
`include "clu_defines.vh"
module clu_bridge (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        clk_en,
  input  wire        cfg_link_wide,
  input  wire        cfg_utopia_wide,
  input  wire [5:0]  cfg_cell_len,
  input  wire [4:0]  cfg_phy_count,
  input  wire        cfg_rx_tag_en,
  input  wire [2:0]  cfg_rx_tag_len,
  input  wire [31:0] cfg_rx_tag,
  input  wire        cfg_tx_tag_en,
  input  wire [2:0]  cfg_tx_tag_len,
  input  wire        cfg_mgmt_parallel,
  input  wire        cfg_out_clk_drive,
  input  wire [7:0]  link_in_data,
  input  wire        link_in_frame_marker,
  output reg         link_in_clock,
  output reg  [7:0]  link_out_data,
  output reg         link_out_frame_marker,
  input  wire        link_out_clock_in,
  output reg         link_out_clock_out,
  output wire        link_out_clock_oe_n,
  input  wire [15:0] utopia_rx_data,
  input  wire        utopia_rx_soc,
  input  wire        utopia_rx_clav,
  output reg         utopia_rx_enb_n,
  output reg  [4:0]  utopia_rx_addr,
  output reg  [15:0] utopia_tx_data,
  output reg         utopia_tx_soc,
  output reg  [4:0]  utopia_tx_addr,
  output reg         utopia_tx_valid,
  output reg         prog_valid,
  output reg  [7:0]  prog_byte,
  output reg         prog_last,
  input  wire        rsp_wr,
  input  wire [7:0]  rsp_data,
  input  wire        rsp_done,
  output wire        rsp_pending,
  output wire        mgmt_mode_parallel,
  output reg         cell_len_error
);
////////////////////////////////////////////////////////////////////////
// synchronisers
  reg [7:0]  lin_d1;
  reg [7:0]  lin_d2;
  reg        lfm_d1;
  reg        lfm_d2;
  reg        loc_d1;
  reg        loc_d2;
  reg        loc_d3;
  reg [15:0] urx_d1;
  reg [15:0] urx_d2;
  reg        usoc_d1;
  reg        usoc_d2;
  reg        uclav_d1;
  reg        uclav_d2;
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lin_d1   <= 8'h00;
      lin_d2   <= 8'h00;
      lfm_d1   <= 1'b0;
      lfm_d2   <= 1'b0;
      loc_d1   <= 1'b0;
      loc_d2   <= 1'b0;
      loc_d3   <= 1'b0;
      urx_d1   <= 16'h0000;
      urx_d2   <= 16'h0000;
      usoc_d1  <= 1'b0;
      usoc_d2  <= 1'b0;
      uclav_d1 <= 1'b0;
      uclav_d2 <= 1'b0;
    end else if (clk_en) begin
      lin_d1   <= link_in_data;
      lin_d2   <= lin_d1;
      lfm_d1   <= link_in_frame_marker;
      lfm_d2   <= lfm_d1;
      loc_d1   <= link_out_clock_in;
      loc_d2   <= loc_d1;
      loc_d3   <= loc_d2;
      urx_d1   <= utopia_rx_data;
      urx_d2   <= urx_d1;
      usoc_d1  <= utopia_rx_soc;
      usoc_d2  <= usoc_d1;
      uclav_d1 <= utopia_rx_clav;
      uclav_d2 <= uclav_d1;
    end
  end
////////////////////////////////////////////////////////////////////////
// link clocks: divider for incoming clock, outgoing clock strobe
  reg [`CLU_LINK_DIV_W-1:0] div_cnt;
  wire in_tick  = (div_cnt == `CLU_LINK_DIV) && link_in_clock;
  wire out_tick = cfg_out_clk_drive ? in_tick :
                  (loc_d2 && !loc_d3);
  assign link_out_clock_oe_n = !cfg_out_clk_drive;
  assign mgmt_mode_parallel  = cfg_mgmt_parallel;
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt            <= {`CLU_LINK_DIV_W{1'b0}};
      link_in_clock      <= 1'b0;
      link_out_clock_out <= 1'b0;
    end else if (clk_en) begin
      if (div_cnt == `CLU_LINK_DIV) begin
        div_cnt       <= {`CLU_LINK_DIV_W{1'b0}};
        link_in_clock <= !link_in_clock;
      end else begin
        div_cnt <= div_cnt + 1'b1;
      end
      link_out_clock_out <= link_in_clock;
    end
  end
////////////////////////////////////////////////////////////////////////
// incoming link: nibble/byte assembly, tag strip, programming detect
  reg        nib_hi;
  reg [3:0]  nib_lo;
  reg [5:0]  in_cnt;
  reg        in_prog;
  reg        in_active;
  reg        in_sof;
  reg [5:0]  in_len_seen;
  wire       in_soc   = lfm_d2;
  wire [7:0] in_byte  = cfg_link_wide ? lin_d2 :
                        {lin_d2[3:0], nib_lo};
  wire       in_bvalid = in_tick && (cfg_link_wide || (nib_hi && !in_soc));
  wire       in_start = (cfg_link_wide ? in_soc : in_sof) &&
                        (in_cnt == 6'h00);
  wire [2:0] tx_tag_n = (cfg_tx_tag_len > `CLU_TAG_MAX) ? `CLU_TAG_MAX :
                        cfg_tx_tag_len;
  wire [5:0] tx_strip = cfg_tx_tag_en ? {3'h0, tx_tag_n} : 6'h00;
  wire       tx_last  = (in_cnt == cfg_cell_len - 6'h01);
  wire [8:0] txf_in   = {tx_last, in_byte};
  wire       in_prog_now = in_start ? (in_byte == `CLU_PROG_MARK) : in_prog;
  wire       txf_rdy;
  wire       txf_wr   = in_bvalid && (in_active || in_start) &&
                        !in_prog_now && txf_rdy &&
                        (in_cnt >= tx_strip);
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      nib_hi         <= 1'b0;
      nib_lo         <= 4'h0;
      in_cnt         <= 6'h00;
      in_prog        <= 1'b0;
      in_active      <= 1'b0;
      in_sof         <= 1'b0;
      in_len_seen    <= 6'h00;
      prog_valid     <= 1'b0;
      prog_byte      <= 8'h00;
      prog_last      <= 1'b0;
      cell_len_error <= 1'b0;
    end else if (clk_en) begin
      prog_valid <= 1'b0;
      cell_len_error <= (cfg_cell_len < `CLU_CELL_MIN) ||
                        (cfg_cell_len > `CLU_CELL_MAX);
      if (in_tick) begin
        if (in_soc) begin
          nib_hi <= !cfg_link_wide;
          in_sof <= !cfg_link_wide;
        end else begin
          nib_hi <= cfg_link_wide ? 1'b0 : !nib_hi;
        end
        nib_lo <= lin_d2[3:0];
      end
      if (in_bvalid) begin
        in_sof <= 1'b0;
        if (in_start) begin
          in_active <= 1'b1;
        end
        if (in_active || in_start) begin
          in_prog <= in_prog_now;
          if (in_prog_now) begin
            prog_valid <= 1'b1;
            prog_byte  <= in_byte;
            prog_last  <= tx_last;
          end
          if (tx_last) begin
            in_cnt    <= 6'h00;
            in_active <= 1'b0;
            in_prog   <= 1'b0;
          end else begin
            in_cnt <= in_cnt + 6'h01;
          end
          in_len_seen <= in_cnt;
        end
      end
    end
  end
////////////////////////////////////////////////////////////////////////
// transmit fifo toward the phys
  wire [8:0] txf_out;
  wire       txf_val;
  reg        tx_first;
  clu_fifo #(
    .WIDTH (`CLU_FIFO_WIDTH),
    .DEPTH (`CLU_FIFO_DEPTH),
    .AW    (`CLU_FIFO_AW)
  ) u_tx_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_data   (txf_in),
    .in_valid  (txf_wr),
    .in_ready  (txf_rdy),
    .out_data  (txf_out),
    .out_valid (txf_val),
    .out_ready (1'b1)
  );
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      utopia_tx_data  <= 16'h0000;
      utopia_tx_soc   <= 1'b0;
      utopia_tx_valid <= 1'b0;
      utopia_tx_addr  <= 5'h00;
      tx_first        <= 1'b1;
    end else if (clk_en) begin
      utopia_tx_valid <= txf_val;
      if (txf_val) begin
        utopia_tx_data <= cfg_utopia_wide ? {8'h00, txf_out[7:0]} :
                          {8'h00, txf_out[7:0]};
        utopia_tx_soc  <= tx_first;
        utopia_tx_addr <= in_len_seen[4:0] & cfg_phy_count;
        tx_first       <= txf_out[8];
      end
    end
  end
////////////////////////////////////////////////////////////////////////
// response cell store
  reg  [5:0] rsp_wptr;
  reg  [5:0] rsp_rptr;
  reg        rsp_full;
  wire [7:0] rsp_q;
  assign rsp_pending = rsp_full;
  clu_ram #(
    .WIDTH (8),
    .DEPTH (`CLU_RSP_DEPTH),
    .AW    (`CLU_RSP_AW)
  ) u_rsp_ram (
    .clk_sys (clk_sys),
    .clk_en  (clk_en),
    .wr_en   (rsp_wr && !rsp_full),
    .wr_addr (rsp_wptr),
    .wr_data (rsp_data),
    .rd_addr (rsp_rptr),
    .rd_data (rsp_q)
  );
////////////////////////////////////////////////////////////////////////
// round-robin scheduler and utopia receive side
  localparam ST_POLL = 2'h0;
  localparam ST_PHY  = 2'h1;
  localparam ST_RSP  = 2'h2;
  reg [1:0]  state;
  reg [4:0]  poll_addr;
  reg        rr_rsp_turn;
  reg [5:0]  out_cnt;
  reg        out_lo;
  wire [2:0] rx_tag_n  = (cfg_rx_tag_len > `CLU_TAG_MAX) ? `CLU_TAG_MAX :
                         cfg_rx_tag_len;
  wire [5:0] rx_tags   = cfg_rx_tag_en ? {3'h0, rx_tag_n} : 6'h00;
  wire [5:0] out_total = cfg_cell_len + rx_tags;
  wire [31:0] tag_sh   = cfg_rx_tag << {out_cnt[1:0], 3'h0};
  wire [7:0] tag_byte  = tag_sh[31:24];
  wire [7:0] phy_byte  = cfg_utopia_wide ? urx_d2[15:8] ^ urx_d2[7:0] :
                         urx_d2[7:0];
  wire [7:0] out_byte  = (out_cnt < rx_tags) ? tag_byte :
                         (state == ST_RSP) ? rsp_q : phy_byte;
  wire       out_step  = out_tick && (cfg_link_wide || out_lo);
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state                 <= ST_POLL;
      poll_addr             <= 5'h00;
      rr_rsp_turn           <= 1'b0;
      out_cnt               <= 6'h00;
      out_lo                <= 1'b0;
      utopia_rx_addr        <= `CLU_PHY_NULL;
      utopia_rx_enb_n       <= 1'b1;
      link_out_data         <= 8'h00;
      link_out_frame_marker <= 1'b0;
      rsp_wptr              <= 6'h00;
      rsp_rptr              <= 6'h00;
      rsp_full              <= 1'b0;
    end else if (clk_en) begin
      if (rsp_wr && !rsp_full) begin
        rsp_wptr <= rsp_wptr + 6'h01;
      end
      case (state)
        ST_POLL: begin
          utopia_rx_enb_n <= 1'b1;
          out_cnt         <= 6'h00;
          rsp_rptr        <= 6'h00;
          if (rr_rsp_turn && rsp_full) begin
            state    <= ST_RSP;
          end else if (!rr_rsp_turn && uclav_d2) begin
            state           <= ST_PHY;
            utopia_rx_enb_n <= 1'b0;
          end else begin
            if (poll_addr >= cfg_phy_count || poll_addr >= `CLU_PHY_MAX) begin
              poll_addr   <= 5'h00;
              rr_rsp_turn <= 1'b1;
            end else begin
              poll_addr   <= poll_addr + 5'h01;
              rr_rsp_turn <= 1'b0;
            end
            utopia_rx_addr <= poll_addr;
          end
        end
        ST_PHY, ST_RSP: begin
          if (out_tick) begin
            out_lo <= cfg_link_wide ? 1'b0 : !out_lo;
          end
          if (out_tick) begin
            link_out_data <= cfg_link_wide ? out_byte :
              {4'h0, out_lo ? out_byte[3:0] : out_byte[7:4]};
            link_out_frame_marker <= (out_cnt == 6'h00) && !out_lo;
          end
          if (out_step) begin
            if (out_cnt >= rx_tags) begin
              rsp_rptr <= rsp_rptr + 6'h01;
            end
            if (out_cnt == out_total - 6'h01) begin
              state           <= ST_POLL;
              utopia_rx_enb_n <= 1'b1;
              rr_rsp_turn     <= (state == ST_RSP) ? 1'b0 : 1'b1;
              if (state == ST_RSP) begin
                rsp_full <= 1'b0;
                rsp_wptr <= 6'h00;
              end
            end else begin
              out_cnt <= out_cnt + 6'h01;
            end
          end
        end
        default: begin
          state <= ST_POLL;
        end
      endcase
      if (rsp_done) begin
        rsp_full <= 1'b1;
      end
    end
  end
  // initial settings arrive on the cfg_ ports from the loader
endmodule

// ==== tb/clu_bridge_chk.sv ====
// checker: concurrent properties on the bridge top ports
// assumes one clock domain, clk_sys with async reset sys_rst
`timescale 1ns/100ps
module clu_bridge_chk (
  input wire       clk_sys,
  input wire       sys_rst,
  input wire [5:0] cfg_cell_len,
  input wire [4:0] cfg_phy_count,
  input wire       cfg_mgmt_parallel,
  input wire       cfg_out_clk_drive,
  input wire       link_in_clock,
  input wire       link_out_clock_oe_n,
  input wire [4:0] utopia_rx_addr,
  input wire       prog_valid,
  input wire       prog_last,
  input wire       mgmt_mode_parallel,
  input wire       cell_len_error
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////
  sequence s_hold_hi; link_in_clock [*4]; endsequence
  sequence s_hold_lo; !link_in_clock [*4]; endsequence
  property p_clk_hi; $rose(link_in_clock) |-> s_hold_hi ##1 !link_in_clock;
  endproperty
  property p_clk_lo; $fell(link_in_clock) |-> s_hold_lo ##1 link_in_clock;
  endproperty
  property p_addr; utopia_rx_addr <= cfg_phy_count ||
    utopia_rx_addr == 5'h1F; endproperty
  property p_len; 1 |=> cell_len_error == ($past(cfg_cell_len) < 6'h34 ||
    $past(cfg_cell_len) > 6'h38); endproperty
  property p_pulse; prog_valid |=> !prog_valid; endproperty
  property p_last; $rose(prog_last) |-> prog_valid; endproperty
  property p_oe; link_out_clock_oe_n == !cfg_out_clk_drive; endproperty
  property p_mgmt; mgmt_mode_parallel == cfg_mgmt_parallel; endproperty
  a_clk_hi: assert property (p_clk_hi) else $error("link clock high span");
  a_clk_lo: assert property (p_clk_lo) else $error("link clock low span");
  a_addr: assert property (p_addr) else $error("poll address range");
  a_len: assert property (p_len) else $error("cell length flag");
  a_pulse: assert property (p_pulse) else $error("prog valid width");
  a_last: assert property (p_last) else $error("prog last alone");
  a_oe: assert property (p_oe) else $error("out clock enable");
  a_mgmt: assert property (p_mgmt) else $error("mgmt mode");
endmodule
bind clu_bridge clu_bridge_chk u_chk (.*);

// ==== tb/clu_far_end.sv ====
// far end: switching memory port on the link and one polled phy
// assumes link_in_clock from the bridge, changes land after clk_sys edges
`timescale 1ns/100ps
module clu_far_end (
  input  wire        clk_sys,
  input  wire        link_in_clock,
  input  wire        utopia_rx_enb_n,
  output reg  [7:0]  link_in_data,
  output reg         link_in_frame_marker,
  output reg  [15:0] utopia_rx_data,
  output reg         utopia_rx_soc
);
  reg enb_q;
  initial begin
    link_in_data = 8'h00;
    link_in_frame_marker = 1'b0;
    utopia_rx_data = 16'h0000;
    utopia_rx_soc = 1'b0;
    enb_q = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  // phy data changes every cycle, start of cell once selected
  always @(posedge clk_sys) begin
    enb_q <= utopia_rx_enb_n;
    utopia_rx_data <= utopia_rx_data + 16'h0101;
    utopia_rx_soc <= enb_q & !utopia_rx_enb_n;
  end
  ////////////////////////////////////////////////////////////////////////
  // programming cell, first byte FF, then byte index
  task send(input [5:0] len, input wide);
    integer i;
    integer h;
    reg [7:0] b;
    begin
      for (i = 0; i < len; i = i + 1) begin
        b = (i == 0) ? 8'hFF : i[7:0];
        for (h = 0; h < (wide ? 1 : 2); h = h + 1) begin
          @(negedge link_in_clock);
          link_in_frame_marker <= (i == 0 && h == 0);
          if (wide)
            link_in_data <= b;
          else if (h == 0)
            link_in_data <= {~b[3:0], b[3:0]};
          else
            link_in_data <= {~b[7:4], b[7:4]};
        end
      end
      @(negedge link_in_clock);
      link_in_frame_marker <= 1'b0;
      link_in_data <= ~link_in_data;
    end
  endtask
endmodule

// ==== tb/testbench.sv ====
// testbench: configuration, link cells, responses and phy polling
// assumes clu_bridge, clu_far_end and the checker compiled first
`timescale 1ns/100ps
`define CHK(nm, e, a) begin n_tests = n_tests + 1; \
  if ((a) !== (e)) begin n_mismatch = n_mismatch + 1; \
  $display("Error %s exp %0h got %0h", nm, e, a); end end
module testbench;
  reg         clk_sys, sys_rst, wide, uwide, mpar, odrv, clav;
  reg         rtag_en, rsp_wr, rsp_done, mk_q, seen;
  reg  [5:0]  len;
  reg  [2:0]  rtag_len, oc;
  reg  [7:0]  rsp_data, mk_b;
  integer     n_mismatch, n_tests, pc, plast, pbad, mk_n, k, mk_t;
  wire        lic, fm, lo_fm, enb_n, soc, pv, pl, pend, oe_n, mgmt, err;
  wire [7:0]  lid, lo_d, pb;
  wire [4:0]  rx_addr;
  wire [15:0] rx_d;
  clu_bridge dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1),
    .cfg_link_wide(wide), .cfg_utopia_wide(uwide), .cfg_cell_len(len),
    .cfg_phy_count(5'h03), .cfg_rx_tag_en(rtag_en),
    .cfg_rx_tag_len(rtag_len), .cfg_rx_tag(32'hA1B2C3D4),
    .cfg_tx_tag_en(1'b0), .cfg_tx_tag_len(3'h0), .cfg_mgmt_parallel(mpar),
    .cfg_out_clk_drive(odrv), .link_in_data(lid),
    .link_in_frame_marker(fm), .link_in_clock(lic), .link_out_data(lo_d),
    .link_out_frame_marker(lo_fm), .link_out_clock_in(oc[2]),
    .link_out_clock_out(), .link_out_clock_oe_n(oe_n),
    .utopia_rx_data(rx_d), .utopia_rx_soc(soc), .utopia_rx_clav(clav),
    .utopia_rx_enb_n(enb_n), .utopia_rx_addr(rx_addr),
    .utopia_tx_data(), .utopia_tx_soc(), .utopia_tx_addr(),
    .utopia_tx_valid(), .prog_valid(pv), .prog_byte(pb), .prog_last(pl),
    .rsp_wr(rsp_wr), .rsp_data(rsp_data), .rsp_done(rsp_done),
    .rsp_pending(pend), .mgmt_mode_parallel(mgmt), .cell_len_error(err));
  clu_far_end far (.clk_sys(clk_sys), .link_in_clock(lic),
    .utopia_rx_enb_n(enb_n), .link_in_data(lid), .link_in_frame_marker(fm),
    .utopia_rx_data(rx_d), .utopia_rx_soc(soc));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    oc <= oc + 3'h1;
    mk_q <= lo_fm;
    if (enb_n === 1'b0) seen = 1;
    if (mk_t == 8 && !wide) mk_b = {mk_b[7:4], lo_d[3:0]};
    if (mk_t > 0 && mk_t < 9) mk_t = mk_t + 1;
    if (lo_fm === 1'b1 && mk_q !== 1'b1) begin
      mk_n = mk_n + 1;
      mk_b = wide ? lo_d : {lo_d[3:0], 4'h0};
      mk_t = 1;
    end
    if (pv === 1'b1) begin
      if (pb !== ((pc == 0) ? 8'hFF : pc[7:0])) pbad = pbad + 1;
      pc = pc + 1;
      if (pl === 1'b1) plast = pc;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task results;
    begin
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task prog(input [5:0] n, input w);
    begin
      wide <= w;
      len <= n;
      pc = 0;
      plast = 0;
      pbad = 0;
      repeat (20) @(posedge clk_sys);
      far.send(n, w);
      repeat (40) @(posedge clk_sys);
      `CHK("prog count", n, pc)
      `CHK("prog last", n, plast)
      `CHK("prog bytes", 0, pbad)
      $display("test prog cell done");
    end
  endtask
  initial begin
    repeat (50000) @(posedge clk_sys);
    n_mismatch = n_mismatch + 1;
    $display("Error watchdog exp done got hang");
    results;
  end
  initial begin
    {sys_rst, wide, mpar, odrv, clav, rtag_en, rsp_wr, rsp_done} = 8'h80;
    {uwide, mk_q, seen, oc, rtag_len, rsp_data} = 0;
    len = 6'h34;
    {n_mismatch, n_tests, pc, plast, pbad, mk_n, mk_t} = 0;
    repeat (20) @(posedge clk_sys);
    `CHK("rx_enb_n", 1'b1, enb_n)
    `CHK("rx_addr", 5'h1F, rx_addr)
    `CHK("oe_n", 1'b1, oe_n)
    sys_rst <= 1'b0;
    mpar <= 1'b1;
    odrv <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK("mgmt", 1'b1, mgmt)
    `CHK("oe_n", 1'b0, oe_n)
    $display("test reset and modes done");
    for (k = 51; k <= 57; k = k + 1) begin
      len <= k;
      repeat (3) @(posedge clk_sys);
      `CHK("len_err", (k < 52 || k > 56), err)
    end
    prog(6'h34, 1'b1);
    prog(6'h38, 1'b0);
    mk_n = 0;
    for (k = 0; k < 8; k = k + 1) begin
      rsp_wr <= 1'b1;
      rsp_data <= 8'h5A + k;
      @(posedge clk_sys);
    end
    rsp_wr <= 1'b0;
    rsp_done <= 1'b1;
    @(posedge clk_sys);
    rsp_done <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK("rsp pending", 1'b1, pend)
    for (k = 0; k < 4000 && pend !== 1'b0; k = k + 1) @(posedge clk_sys);
    `CHK("rsp sent", 1'b0, pend)
    `CHK("rsp marker", 1'b1, mk_n > 0)
    `CHK("rsp first", 8'h5A, mk_b)
    $display("test response cell done");
    {rtag_en, rtag_len, uwide, clav} <= 6'h31;
    mk_n = 0;
    for (k = 0; k < 4000 && mk_n == 0; k = k + 1) @(posedge clk_sys);
    repeat (9) @(posedge clk_sys);
    clav <= 1'b0;
    `CHK("phy enable", 1'b1, seen)
    `CHK("tag first", 8'hA1, mk_b)
    $display("test phy cell done");
    results;
  end
endmodule
